// ==== bench/tb_rpfe_top.sv ====
// Bench for the flush engine top: register tests over AXI4-Lite.
// Assumes the package register map; the bench also drives the learning port.
`timescale 1ns/1ps
module tb_rpfe_top;
  import rpfe_pkg::*;
  // ****************************************************************
  // Signals and tables
  // ****************************************************************
  logic        clk = 1'b0, reset = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
  logic [2:0]  egress_port = 3'h0, learn_port = 3'h0;
  logic        learn_valid = 1'b0;
  logic [16:0] learn_id = 17'h00000;
  logic [3:0]  egress_key_port, ifg_bytes;
  logic        flush_done, low_power, temp_refresh;
  logic [7:0]  clock_period_tenths, ts_step_tenths;
  int          err_count = 0, checks_done = 0, cyc = 0, done_cnt = 0;
  int          tr_cnt = 0, tr_last = 0, tr_gap = 0;
  // Address entries {valid,id,lport}: match, wrong port, wrong id, unused id
  logic [31:0] md [4] = '{32'h2000a7, 32'h2000a2, 32'h200637, 32'h3ffff7};
  logic        mv [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  // VLAN entries {ring,ports}: two in range on ring 1, one out of range, one other ring
  logic [5:0]  vi [4] = '{6'd10, 6'd20, 6'd5, 6'd30};
  logic [31:0] vd [4] = '{32'h1883, 32'h1080, 32'h1080, 32'h0803};
  logic [31:0] ve [4] = '{32'h1983, 32'h1180, 32'h1080, 32'h0803};

  rpfe_top rpfe_top_inst (.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .learn_valid, .learn_port, .learn_id, .egress_port,
    .egress_key_port, .flush_done, .low_power, .clock_period_tenths, .ifg_bytes, .temp_refresh,
    .ts_step_tenths);

  // 50 MHz clock
  always #10 clk = ~clk;

  // Count flush completions and time temperature ticks; the ceiling leaves room
  // for two full refresh intervals at full rate, then cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (flush_done === 1'b1) done_cnt++;
    if (temp_refresh === 1'b1) begin
      tr_gap = cyc - tr_last;
      tr_last = cyc;
      tr_cnt++;
    end
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready and answers are taken at the rising edge; each channel drops right after
  // the edge that took it. One idle edge ends each call, so back to back calls
  // never assign a handshake signal twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_q   = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(32'(clock_period_tenths), 32'(PERIOD_NORM));
    chk(32'(ifg_bytes), 32'(IFG_NORM));
    rd(OFF_CTRL);
    chk(rd_q, CTRL_RESET);
    rd(OFF_IDS);
    chk(rd_q, 32'(ID_UNUSED));
    rd(8'h3c);
    chk(32'(resp_q), 32'h2);
    wr(8'h3c, 32'h0000_0000);
    chk(32'(resp_q), 32'h2);
    // Port 2 shares logical port 5 in the egress key
    wr(OFF_LPORT, 32'h500);
    chk(32'(resp_q), 32'h0);
    egress_port <= 3'h2;
    repeat (3) @(posedge clk);
    chk(32'(egress_key_port), 32'h5);
    // An address learned on port 2 is stored against logical port 5
    learn_port  <= 3'h2;
    learn_id    <= 17'h0000b;
    learn_valid <= 1'b1;
    @(posedge clk);
    learn_valid <= 1'b0;
    wr(OFF_MADDR, 32'h0000_000b);
    rd(OFF_MDATA);
    chk(rd_q, 32'h0020_00b5);
    foreach (md[i]) begin
      wr(OFF_MADDR, 32'(i));
      wr(OFF_MDATA, md[i]);
    end
    foreach (vd[i]) begin
      wr(OFF_VADDR, 32'(vi[i]));
      wr(OFF_VDATA, vd[i]);
    end
    wr(OFF_IDS, 32'd10);
    wr(OFF_FLT, 32'h180);
    wr(OFF_BULK_TABLE_UPDATE_RNG, 32'd10 | (32'd50 << 6));
    wr(OFF_BULK_TABLE_UPDATE_MSK, 32'h0100_0002);
    // Both engines start together; the repeat lands while they run
    wr(OFF_CTRL, 32'h3f);
    wr(OFF_CTRL, 32'h3f);
    rd(OFF_STATUS);
    chk(32'(rd_q[1]), 32'h1);
    repeat (200) begin
      rd(OFF_CTRL);
      if (rd_q[1:0] === 2'b00) break;
    end
    repeat (3) @(posedge clk);
    chk(32'(rd_q[1:0]), 32'h0);
    chk(32'(done_cnt), 32'h1);
    foreach (md[i]) begin
      wr(OFF_MADDR, 32'(i));
      rd(OFF_MDATA);
      chk(32'(rd_q[21]), 32'(mv[i]));
    end
    foreach (vd[i]) begin
      wr(OFF_VADDR, 32'(vi[i]));
      rd(OFF_VDATA);
      chk(rd_q, ve[i]);
    end
    // Two temperature ticks time one refresh interval at full rate
    while (tr_cnt < 2) @(posedge clk);
    chk(32'(tr_gap), 32'(TEMP_CYC_NORM));
    wr(OFF_CTRL, 32'h40);
    repeat (3) @(posedge clk);
    chk(32'(low_power), 32'h1);
    chk(32'(clock_period_tenths), 32'd192);
    chk(32'(ts_step_tenths), 32'd192);
    chk(32'(ifg_bytes), 32'd14);
    stop_test();
  end
endmodule : tb_rpfe_top

// ==== rtl/rpfe_bulk_table_update.sv ====
// Bulk VLAN table update engine: sweeps an address range and ORs a port set
// into selected entries.
// Assumes the parent owns the table and applies the write strobe it issues.
`timescale 1ns/1ps
module rpfe_bulk_table_update
  import rpfe_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Command
  input  wire logic                 start,
  input  wire logic                 ring_en,
  input  wire logic [RING_BITS-1:0] ring_mask,
  input  wire logic [5:0]           addr_lo,
  input  wire logic [5:0]           addr_hi,
  input  wire logic [PORT_BITS-1:0] port_set,
  // Table access
  output logic [5:0]                idx,
  input  wire rpfe_vlan_t           rd_entry,
  output logic                      wr_en,
  output rpfe_vlan_t                wr_entry,
  output logic                      busy,
  output logic                      done
);
  import rpfe_pkg::*;

  logic       busy_q, busy_d;
  logic [5:0] idx_q, idx_d;
  logic       sel;

  // One entry per cycle; an empty range still visits addr_lo for one cycle, then finishes
  always_comb begin
    busy_d   = busy_q;
    idx_d    = idx_q;
    done     = 1'b0;
    sel      = !ring_en || |(rd_entry.ring_member_bits & ring_mask);
    wr_en    = busy_q && sel;
    wr_entry = rd_entry;
    wr_entry.vlan_egress_ports = rd_entry.vlan_egress_ports | port_set;
    if (!busy_q && start) begin
      busy_d = 1'b1;
      idx_d  = addr_lo;
    end else if (busy_q) begin
      if (idx_q >= addr_hi || idx_q == 6'h3f) begin
        busy_d = 1'b0;
        done   = 1'b1;
      end else begin
        idx_d = idx_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      idx_q  <= 6'h00;
    end else begin
      busy_q <= busy_d;
      idx_q  <= idx_d;
    end
  end

  assign idx  = idx_q;
  assign busy = busy_q;

  a_bulk_table_update_range: assert property (@(posedge clk) disable iff (reset)
    busy_q && wr_en |-> idx_q >= addr_lo)
    else $error("bulk update outside range");

endmodule : rpfe_bulk_table_update

// ==== rtl/rpfe_pkg.sv ====
// Package for the ring protection flush engine: register map, field layout,
// reset values, timing counts and shared types.
// Assumes a single 50 MHz core clock and an AXI4-Lite register master.
package rpfe_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int VLAN_ENTRIES = 64;
  localparam int MAC_ENTRIES  = 32;
  localparam int ID_SLOTS     = 16;
  localparam int RING_BITS    = 16;
  localparam int PORT_BITS    = 11;
  localparam int ID_BITS      = 17;
  localparam int LPORT_BITS   = 4;
  localparam int NUM_PORTS    = 6;
  localparam logic [16:0] ID_UNUSED = 17'h1ffff;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_FLT      = 8'h08;
  localparam logic [7:0] OFF_BULK_TABLE_UPDATE_RNG = 8'h0c;
  localparam logic [7:0] OFF_BULK_TABLE_UPDATE_MSK = 8'h10;
  localparam logic [7:0] OFF_VADDR    = 8'h14;
  localparam logic [7:0] OFF_VDATA    = 8'h18;
  localparam logic [7:0] OFF_MADDR    = 8'h1c;
  localparam logic [7:0] OFF_MDATA    = 8'h20;
  localparam logic [7:0] OFF_LPORT    = 8'h24;
  localparam logic [7:0] OFF_TIMING   = 8'h28;
  localparam logic [7:0] OFF_IDS      = 8'h40;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int CTRL_TRIGGER  = 0;
  localparam int CTRL_BULK_TABLE_UPDATE_GO  = 1;
  localparam int CTRL_ID_EN    = 2;
  localparam int CTRL_PORT_EN  = 3;
  localparam int CTRL_REMOVE   = 4;
  localparam int CTRL_RING_EN  = 5;
  localparam int CTRL_LOWPWR   = 6;
  localparam int CTRL_DONE_EN  = 7;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam int          CLK_MHZ      = 50;
  localparam int          TEMP_US_NORM = 500;
  localparam int          TEMP_US_LOW  = 1500;
  localparam int          TEMP_CYC_NORM = TEMP_US_NORM * CLK_MHZ;
  localparam int          TEMP_CYC_LOW  = TEMP_US_LOW * CLK_MHZ;
  localparam logic [7:0]  PERIOD_NORM  = 8'h40;
  localparam logic [7:0]  PERIOD_LOW   = 8'hc0;
  localparam logic [3:0]  IFG_NORM     = 4'hc;
  localparam logic [3:0]  IFG_LOW      = 4'he;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [RING_BITS-1:0] ring_member_bits;
    logic [PORT_BITS-1:0] vlan_egress_ports;
  } rpfe_vlan_t;

  typedef struct packed {
    logic                 valid;
    logic [ID_BITS-1:0]   entry_forward_id;
    logic [LPORT_BITS-1:0] learn_logical_port;
  } rpfe_mac_t;

  typedef enum logic [1:0] {
    SCAN_IDLE, SCAN_RUN, SCAN_DONE
  } rpfe_scan_t;

endpackage : rpfe_pkg

// ==== rtl/rpfe_top.sv ====
// Top of the ring protection flush engine: AXI4-Lite register slave, VLAN
// and address tables, address flush scan, logical port mapping, low power.
// Assumes reset asserted at power up and a well behaved AXI4-Lite master.
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rpfe_top
  import rpfe_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // AXI4-Lite write address and data
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Learning and rewriting
  input  wire logic                  learn_valid,
  input  wire logic [2:0]            learn_port,
  input  wire logic [ID_BITS-1:0]    learn_id,
  input  wire logic [2:0]            egress_port,
  output logic [LPORT_BITS-1:0]      egress_key_port,
  // Status and low power outputs
  output logic                       flush_done,
  output logic                       low_power,
  output logic [7:0]                 clock_period_tenths,
  output logic [3:0]                 ifg_bytes,
  output logic                       temp_refresh,
  output logic [7:0]                 ts_step_tenths
);
  import rpfe_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [31:0]           ctrl_q, ctrl_d;
  logic [PORT_BITS-1:0]  filt_q, filt_d;
  logic [RING_BITS-1:0]  ring_q, ring_d;
  logic [11:0]           rng_q, rng_d;
  logic [PORT_BITS-1:0]  pset_q, pset_d;
  logic [5:0]            vaddr_q, vaddr_d;
  logic [4:0]            maddr_q, maddr_d;
  logic [23:0]           lport_q, lport_d;
  logic [ID_BITS-1:0]    ids_q [ID_SLOTS];
  logic [ID_BITS-1:0]    ids_d [ID_SLOTS];
  rpfe_vlan_t            vlan_q [VLAN_ENTRIES];
  rpfe_mac_t             mac_q [MAC_ENTRIES];
  logic                  done_sticky_q, done_sticky_d;

  // AXI handshake state
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  // Scan state
  rpfe_scan_t  st_q, st_d;
  logic [4:0]  sidx_q, sidx_d;
  logic        hit;
  logic        id_hit;

  // Bulk update wiring
  logic [5:0]  t_idx;
  logic        t_wr, t_busy, t_done;
  rpfe_vlan_t  t_wr_entry;

  logic        wr_fire, rd_fire;
  logic        vdata_wr, mdata_wr;
  logic [7:0]  wa;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data may come in either order; write commits when both held
  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    b_d   = b_q;
    br_d  = br_q;
    if (s_axi_awvalid && !aw_q && !b_q) begin
      aw_d  = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    wr_fire = aw_q && w_q && !b_q;
    wa      = awa_q;
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = (wa <= OFF_TIMING || (wa >= OFF_IDS && wa < 8'h80)) ? 2'b00 : 2'b10;
    end else if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
  end

  // Reads answer one cycle after acceptance; unmapped reads give SLVERR
  always_comb begin
    r_d     = r_q;
    rd_d    = rd_q;
    rr_d    = rr_q;
    rd_fire = s_axi_arvalid && !r_q;
    if (rd_fire) begin
      r_d  = 1'b1;
      rr_d = 2'b00;
      rd_d = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_CTRL:     rd_d = ctrl_q;
        OFF_STATUS:   rd_d = {28'h0, done_sticky_q, t_busy, st_q == SCAN_RUN, low_power};
        OFF_FLT:      rd_d = {21'h0, filt_q};
        OFF_BULK_TABLE_UPDATE_RNG: rd_d = {20'h0, rng_q};
        OFF_BULK_TABLE_UPDATE_MSK: rd_d = {5'h0, pset_q, ring_q};
        OFF_VADDR:    rd_d = {26'h0, vaddr_q};
        OFF_VDATA:    rd_d = {5'h0, vlan_q[vaddr_q]};
        OFF_MADDR:    rd_d = {27'h0, maddr_q};
        OFF_MDATA:    rd_d = {10'h0, mac_q[maddr_q]};
        OFF_LPORT:    rd_d = {8'h0, lport_q};
        OFF_TIMING:   rd_d = {16'h0, ts_step_tenths, clock_period_tenths};
        default: begin
          if (s_axi_araddr >= OFF_IDS && s_axi_araddr < 8'h80) begin
            rd_d = {15'h0, ids_q[s_axi_araddr[5:2]]};
          end else begin
            rr_d = 2'b10;
          end
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Hardware clear of trigger and update start wins over nothing; set by
  // software only when idle, so a retrigger mid-flush is dropped
  always_comb begin
    ctrl_d        = ctrl_q;
    filt_d        = filt_q;
    ring_d        = ring_q;
    rng_d         = rng_q;
    pset_d        = pset_q;
    vaddr_d       = vaddr_q;
    maddr_d       = maddr_q;
    lport_d       = lport_q;
    done_sticky_d = done_sticky_q;
    vdata_wr      = 1'b0;
    mdata_wr      = 1'b0;
    for (int i = 0; i < ID_SLOTS; i++) begin
      ids_d[i] = ids_q[i];
    end
    if (wr_fire) begin
      case (wa)
        OFF_CTRL: begin
          ctrl_d[31:2] = wd_q[31:2];
          if (st_q == SCAN_IDLE) begin
            ctrl_d[CTRL_TRIGGER] = wd_q[CTRL_TRIGGER];
          end
          if (!t_busy) begin
            ctrl_d[CTRL_BULK_TABLE_UPDATE_GO] = wd_q[CTRL_BULK_TABLE_UPDATE_GO];
          end
        end
        OFF_STATUS:   done_sticky_d = done_sticky_q & ~wd_q[3];
        OFF_FLT:      filt_d  = wd_q[PORT_BITS-1:0];
        OFF_BULK_TABLE_UPDATE_RNG: rng_d   = wd_q[11:0];
        OFF_BULK_TABLE_UPDATE_MSK: {pset_d, ring_d} = wd_q[26:0];
        OFF_VADDR:    vaddr_d = wd_q[5:0];
        OFF_VDATA:    vdata_wr = 1'b1;
        OFF_MADDR:    maddr_d = wd_q[4:0];
        OFF_MDATA:    mdata_wr = 1'b1;
        OFF_LPORT:    lport_d = wd_q[23:0];
        default: begin
          if (wa >= OFF_IDS && wa < 8'h80) begin
            ids_d[wa[5:2]] = wd_q[ID_BITS-1:0];
          end
        end
      endcase
    end
    // Self clearing start bits on completion
    if (st_q == SCAN_DONE) begin
      ctrl_d[CTRL_TRIGGER] = 1'b0;
      if (ctrl_q[CTRL_DONE_EN]) begin
        done_sticky_d = 1'b1;
      end
    end
    if (t_done) begin
      ctrl_d[CTRL_BULK_TABLE_UPDATE_GO] = 1'b0;
    end
  end

  // ****************************************************************
  // Flush scan over the address table
  // ****************************************************************
  // One entry per cycle; concurrent with the bulk update engine
  always_comb begin
    id_hit = 1'b0;
    for (int i = 0; i < ID_SLOTS; i++) begin
      if (ids_q[i] != ID_UNUSED && ids_q[i] == mac_q[sidx_q].entry_forward_id) begin
        id_hit = 1'b1;
      end
    end
    hit = mac_q[sidx_q].valid
        && (!ctrl_q[CTRL_ID_EN] || id_hit)
        && (!ctrl_q[CTRL_PORT_EN] || filt_q[mac_q[sidx_q].learn_logical_port]);
    st_d   = st_q;
    sidx_d = sidx_q;
    case (st_q)
      SCAN_IDLE: begin
        if (ctrl_q[CTRL_TRIGGER]) begin
          st_d   = SCAN_RUN;
          sidx_d = 5'h00;
        end
      end
      SCAN_RUN: begin
        if (sidx_q == 5'h1f) begin
          st_d = SCAN_DONE;
        end else begin
          sidx_d = sidx_q + 5'h01;
        end
      end
      SCAN_DONE: st_d = SCAN_IDLE;
      default:   st_d = SCAN_IDLE;
    endcase
  end

  rpfe_bulk_table_update u_bulk_table_update (
    .clk       (clk),
    .reset     (reset),
    .start     (ctrl_q[CTRL_BULK_TABLE_UPDATE_GO]),
    .ring_en   (ctrl_q[CTRL_RING_EN]),
    .ring_mask (ring_q),
    .addr_lo   (rng_q[5:0]),
    .addr_hi   (rng_q[11:6]),
    .port_set  (pset_q),
    .idx       (t_idx),
    .rd_entry  (vlan_q[t_idx]),
    .wr_en     (t_wr),
    .wr_entry  (t_wr_entry),
    .busy      (t_busy),
    .done      (t_done)
  );

  // ****************************************************************
  // Tables; one generate loop per table
  // ****************************************************************
  for (genvar g = 0; g < VLAN_ENTRIES; g++) begin : g_vlan
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        vlan_q[g] <= '0;
      end else if (vdata_wr && vaddr_q == g) begin
        vlan_q[g] <= wd_q[26:0];
      end else if (t_wr && t_idx == g) begin
        vlan_q[g] <= t_wr_entry;
      end
    end
  end

  // Learning stores the logical port, so protection moves need no flush
  for (genvar g = 0; g < MAC_ENTRIES; g++) begin : g_mac
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mac_q[g] <= '0;
      end else if (st_q == SCAN_RUN && sidx_q == g && hit && ctrl_q[CTRL_REMOVE]) begin
        mac_q[g].valid <= 1'b0;
      end else if (mdata_wr && maddr_q == g) begin
        mac_q[g] <= wd_q[21:0];
      end else if (learn_valid && learn_id[4:0] == g) begin
        mac_q[g] <= {1'b1, learn_id, lport_q[learn_port*4 +: 4]};
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      filt_q <= '0;
      ring_q <= '0;
      rng_q <= '0;
      pset_q <= '0;
      vaddr_q <= '0;
      maddr_q <= '0;
      lport_q <= '0;
      done_sticky_q <= 1'b0;
      for (int i = 0; i < ID_SLOTS; i++) ids_q[i] <= ID_UNUSED;
      st_q <= SCAN_IDLE;
      sidx_q <= '0;
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= '0; wd_q <= '0; rd_q <= '0; br_q <= '0; rr_q <= '0;
      egress_key_port <= '0;
      flush_done <= 1'b0;
      low_power <= 1'b0;
      clock_period_tenths <= PERIOD_NORM;
      ifg_bytes <= IFG_NORM;
      ts_step_tenths <= PERIOD_NORM;
    end else begin
      ctrl_q <= ctrl_d;
      filt_q <= filt_d;
      ring_q <= ring_d;
      rng_q <= rng_d;
      pset_q <= pset_d;
      vaddr_q <= vaddr_d;
      maddr_q <= maddr_d;
      lport_q <= lport_d;
      done_sticky_q <= done_sticky_d;
      for (int i = 0; i < ID_SLOTS; i++) ids_q[i] <= ids_d[i];
      st_q <= st_d;
      sidx_q <= sidx_d;
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d; br_q <= br_d; rr_q <= rr_d;
      egress_key_port <= lport_q[egress_port*4 +: 4];
      flush_done <= st_q == SCAN_DONE;
      low_power <= ctrl_q[CTRL_LOWPWR];
      clock_period_tenths <= ctrl_q[CTRL_LOWPWR] ? PERIOD_LOW : PERIOD_NORM;
      ts_step_tenths <= ctrl_q[CTRL_LOWPWR] ? PERIOD_LOW : PERIOD_NORM;
      ifg_bytes <= ctrl_q[CTRL_LOWPWR] ? IFG_LOW : IFG_NORM;
    end
  end

  // ****************************************************************
  // Temperature refresh tick; interval triples in low power
  // ****************************************************************
  logic [16:0] tmp_q, tmp_d;
  logic        tick_q, tick_d;
  always_comb begin
    tick_d = 1'b0;
    tmp_d  = tmp_q + 17'h00001;
    if (tmp_q >= 17'(low_power ? TEMP_CYC_LOW - 1 : TEMP_CYC_NORM - 1)) begin
      tmp_d  = '0;
      tick_d = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmp_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tmp_q  <= tmp_d;
      tick_q <= tick_d;
    end
  end
  assign temp_refresh = tick_q;

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready  = !w_q && !b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_scan_clears: assert property (@(posedge clk) disable iff (reset)
    st_q == SCAN_DONE |=> !ctrl_q[CTRL_TRIGGER])
    else $error("trigger not cleared");
  a_scan_length: assert property (@(posedge clk) disable iff (reset)
    $rose(st_q == SCAN_RUN) |-> ##32 st_q == SCAN_DONE)
    else $error("scan length wrong");
  a_remove_hit: assert property (@(posedge clk) disable iff (reset)
    st_q == SCAN_RUN && hit && ctrl_q[CTRL_REMOVE] |=> !mac_q[$past(sidx_q)].valid)
    else $error("found entry kept");
  a_ifg_low: assert property (@(posedge clk) disable iff (reset)
    ctrl_q[CTRL_LOWPWR] |=> ifg_bytes == IFG_LOW)
    else $error("gap wrong");
  a_period_low: assert property (@(posedge clk) disable iff (reset)
    ctrl_q[CTRL_LOWPWR] |=> clock_period_tenths == PERIOD_LOW)
    else $error("period wrong");
  a_done_pulse: assert property (@(posedge clk) disable iff (reset)
    flush_done |-> $past(st_q) == SCAN_DONE)
    else $error("done without scan");
  a_id_unused: assert property (@(posedge clk) disable iff (reset)
    st_q == SCAN_RUN && ctrl_q[CTRL_ID_EN] && hit |-> id_hit)
    else $error("id filter leaked");
  a_bulk_table_update_clear: assert property (@(posedge clk) disable iff (reset)
    t_done |=> !ctrl_q[CTRL_BULK_TABLE_UPDATE_GO])
    else $error("update start kept");
  c_flush: cover property (@(posedge clk) flush_done);
  c_both: cover property (@(posedge clk) t_busy && st_q == SCAN_RUN);
  c_remove: cover property (@(posedge clk) st_q == SCAN_RUN && hit && ctrl_q[CTRL_REMOVE]);

endmodule : rpfe_top
